// >>> pkg/dapc_pkg.sv
// Package: register map, field layout, mode codes and carriers of the dual action capture/compare unit
package dapc_pkg;
  // Printed word offsets (registers sit at these byte addresses)
  localparam logic [15:0] OFS_STATUS = 16'hf218;
  localparam logic [15:0] OFS_LEAD = 16'hf21a;
  localparam logic [15:0] OFS_TRAIL = 16'hf21c;
  localparam logic [15:0] OFS_RSVD = 16'hf21e;
  // Status/control field positions
  localparam int B_FLAG = 15;
  localparam int B_PRIO_HI = 14;
  localparam int B_PRIO_LO = 12;
  localparam int B_ARB = 11;
  localparam int B_DRIVE = 9;
  localparam int B_BSEL = 8;
  localparam int B_PIN = 7;
  localparam int B_FLEAD = 6;
  localparam int B_FTRAIL = 5;
  localparam int B_POL = 4;
  localparam int B_TOP = 15;
  // Writable control bits (flag, pin level and force bits handled apart)
  localparam logic [15:0] CTRL_WMASK = 16'h7b1f;
  localparam logic [15:0] CTRL_RST = 16'h0000;
  localparam logic [15:0] DATA_RST = 16'h0000;
  // Mode codes
  localparam logic [3:0] M_IDLE = 4'h0;
  localparam logic [3:0] M_PWCAP = 4'h1;
  localparam logic [3:0] M_PERCAP = 4'h2;
  localparam logic [3:0] M_EDGECAP = 4'h3;
  localparam logic [2:0] M_CMP_PFX = 3'b010;
  // Bus-side request carrier
  typedef struct packed {
    logic [15:0] address;
    logic read;
    logic write;
    logic [31:0] writedata;
    logic [3:0] byteenable;
  } dapc_req_t;
  // Bus-side answer carrier
  typedef struct packed {
    logic [31:0] readdata;
    logic waitrequest;
  } dapc_rsp_t;
endpackage

// >>> design/dapc_sync.sv
// Module: two-flop synchroniser for one level from outside the clock domain
module dapc_sync (
  input wire logic core_clk,
  input wire logic srst,
  input wire logic din,
  output logic dout
);
  import dapc_pkg::*;
  // State: first stage and second stage
  typedef struct packed {
    logic s1;
    logic s2;
  } dapc_sync_st_t;
  dapc_sync_st_t st;
  dapc_sync_st_t next_st;
  // Shift the level through both stages
  always_comb begin
    next_st.s1 = din;
    next_st.s2 = st.s1;
  end
  // Register the stages
  always_ff @(posedge core_clk) begin
    if (srst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end
  assign dout = st.s2;
endmodule

// >>> design/dapc_cmp.sv
// Module: masked equality comparator against the time base count
module dapc_cmp (
  input wire logic [15:0] value,
  input wire logic [15:0] count,
  input wire logic [15:0] mask,
  output logic hit
);
  import dapc_pkg::*;
  // Only bits left unmasked take part
  always_comb begin
    hit = ((value ^ count) & mask) == 16'h0000;
  end
endmodule

// >>> design/dapc_unit.sv
// Module: dual action capture/compare unit with Avalon-MM register slave
// Notes on behaviour
// - Top mode bit selects PWM, low bits mask.
// - PWM trail writes buffered, copied between trail and lead.
// - PWM lead match sets output and flag.
// - Trail active match resets output only.
// - Pulses continue regardless of flag.
// - Equal lead and trail match gives zero.
// - Eight PWM periods, 65536 down to 128.
// - Full resolution never reaches permanent high.
// - Reduced resolution trail top bit holds output high.
// - Force bits act like matches in output modes.
// - Both force bits together reset output.
// - Polarity bit inverts flip-flop onto pin.
// - Pin level bit shows input or output.
// - Drive select chooses totem pole or open drain.
// - Bus select picks time base A or B.
// - Nonzero priority raises request when flag set.
// - Arbitration bit extends module arbitration number.
// - Event between read and write blocks clear.
// - Flag sources depend on mode.
// - Halt freezes capture and compare only.
// - Unused bits and reserved location read zero.
// - Mode 0010 is period capture.
// - Mode 0011 is edge capture, first edge flags.
// - Compare modes arm channel on data write.
module dapc_unit (
  input wire logic core_clk,
  input wire logic srst,
  input wire logic [15:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic [15:0] tbb_a,
  input wire logic [15:0] tbb_b,
  input wire logic halt_req,
  input wire logic [2:0] module_arb,
  input wire logic pin_in,
  output logic pin_out,
  output logic pin_oe,
  output logic [2:0] irq_level,
  output logic [3:0] irq_arb_id
);
  import dapc_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Bus request as one carrier
  dapc_req_t req;
  assign req = '{address: avs_address, read: avs_read, write: avs_write,
                 writedata: avs_writedata, byteenable: avs_byteenable};

  // Bus slave phase: idle, then one answer cycle
  typedef enum logic [0:0] {
    BUS_IDLE = 1'b0,
    BUS_ANS = 1'b1
  } dapc_bus_t;

  // All state of the unit
  typedef struct packed {
    dapc_bus_t bus;
    logic [15:0] ctrl;       // Control bits without flag, pin and force
    logic flag;              // Status flag
    logic flag_seen;         // Flag read as set, clear armed
    logic [15:0] lead;       // Lead channel value
    logic [15:0] trail_buf;  // Trail buffer register
    logic [15:0] trail_act;  // Trail active register
    logic arm_lead;          // Compare mode comparator enables
    logic arm_trail;
    logic outff;             // Output flip-flop
    logic in_window;         // Between trail edge and next lead edge
    logic pin_d;             // Previous synchronised pin level
    logic first_done;        // Period capture has seen its first edge
    logic pw_lead_seen;      // Pulse width capture saw its leading edge
    logic [15:0] count_d;    // Count at previous cycle, to catch new values
    logic [31:0] rdata;
  } dapc_st_t;
  dapc_st_t st;
  dapc_st_t next_st;

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchroniser: the pin is outside the clock domain
  logic pin_s;
  dapc_sync u_sync (
    .core_clk(core_clk),
    .srst(srst),
    .din(pin_in),
    .dout(pin_s)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Decoded control fields
  logic [3:0] mode;
  logic pwm_out_mode;
  logic cmp_mode;
  logic out_modes;
  logic pol;
  logic [15:0] count;
  logic [15:0] mask;
  logic new_count;
  assign mode = st.ctrl[3:0];
  assign pwm_out_mode = mode[3];
  assign cmp_mode = (mode[3:1] == M_CMP_PFX);
  assign out_modes = pwm_out_mode | cmp_mode;
  assign pol = st.ctrl[B_POL];
  assign count = st.ctrl[B_BSEL] ? tbb_b : tbb_a;
  // Only act once per count value, so a slow time base yields one match
  assign new_count = (count != st.count_d);

  // Mask table: ratios 65536,32768,16384,8192,4096,2048,512,128
  always_comb begin
    case (mode[2:0])
      3'd0: mask = 16'hffff;
      3'd1: mask = 16'h7fff;
      3'd2: mask = 16'h3fff;
      3'd3: mask = 16'h1fff;
      3'd4: mask = 16'h0fff;
      3'd5: mask = 16'h07ff;
      3'd6: mask = 16'h01ff;
      default: mask = 16'h007f;
    endcase
    if (!pwm_out_mode) begin
      mask = 16'hffff;
    end
  end

  // Comparators for lead and trail
  logic hit_lead;
  logic hit_trail;
  logic [15:0] trail_cmp;
  assign trail_cmp = pwm_out_mode ? st.trail_act : st.trail_buf;
  dapc_cmp u_cmp_lead (
    .value(st.lead),
    .count(count),
    .mask(mask),
    .hit(hit_lead)
  );
  dapc_cmp u_cmp_trail (
    .value(trail_cmp),
    .count(count),
    .mask(mask),
    .hit(hit_trail)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Bus decode
  logic acc;
  logic wr_stat;
  logic wr_lead;
  logic wr_trail;
  logic rd_stat;
  logic [15:0] wdat;
  logic [15:0] status_view;
  logic pin_level;
  assign acc = (st.bus == BUS_IDLE) && (req.read || req.write);
  assign wdat = req.writedata[15:0];
  assign wr_stat = acc && req.write && (req.address == OFS_STATUS) && (&req.byteenable[1:0]);
  assign wr_lead = acc && req.write && (req.address == OFS_LEAD) && (&req.byteenable[1:0]);
  assign wr_trail = acc && req.write && (req.address == OFS_TRAIL) && (&req.byteenable[1:0]);
  assign rd_stat = acc && req.read && (req.address == OFS_STATUS);
  // Pin level: post-polarity output in compare and PWM modes, input pin otherwise
  assign pin_level = out_modes ? (st.outff ^ pol) : pin_s;
  always_comb begin
    status_view = st.ctrl & CTRL_WMASK;
    status_view[B_FLAG] = st.flag;
    status_view[B_PIN] = pin_level;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Next-state logic
  logic ev_flag;
  logic run;
  logic pin_edge_a;
  logic pin_edge_b;
  logic do_lead;
  logic do_trail;
  logic f_lead;
  logic f_trail;
  logic hold_high;
  always_comb begin
    next_st = st;
    ev_flag = 1'b0;
    run = !halt_req;
    next_st.count_d = count;
    next_st.pin_d = pin_s;
    // Edge for channel A per polarity; channel B takes the opposite edge
    pin_edge_a = (pin_s != st.pin_d) && (pin_s == !pol);
    pin_edge_b = (pin_s != st.pin_d) && (pin_s == pol);
    do_lead = 1'b0;
    do_trail = 1'b0;
    f_lead = wr_stat && wdat[B_FLEAD] && out_modes;
    f_trail = wr_stat && wdat[B_FTRAIL] && out_modes;
    hold_high = (mask != 16'hffff) && st.trail_act[B_TOP];

    // Bus phase: every request answered in the cycle after it is taken
    next_st.bus = acc ? BUS_ANS : BUS_IDLE;
    if (acc && req.read) begin
      if (req.address == OFS_STATUS) begin
        next_st.rdata = {16'h0000, status_view};
      end else if (req.address == OFS_LEAD) begin
        next_st.rdata = {16'h0000, st.lead};
      end else if (req.address == OFS_TRAIL) begin
        next_st.rdata = {16'h0000, (pwm_out_mode || mode == M_IDLE) ? st.trail_buf : st.trail_act};
      end else begin
        next_st.rdata = 32'h0000_0000;
      end
    end

    // Register writes
    if (wr_stat) begin
      next_st.ctrl = wdat & CTRL_WMASK;
      if (wdat[3:1] == M_CMP_PFX && !cmp_mode) begin
        next_st.arm_lead = 1'b0;
        next_st.arm_trail = 1'b0;
      end
      if (wdat[3:0] != mode) begin
        next_st.first_done = 1'b0;
        next_st.pw_lead_seen = 1'b0;
      end
    end
    if (wr_lead) begin
      next_st.lead = wdat;
      next_st.arm_lead = 1'b1;
    end
    if (wr_trail) begin
      if (pwm_out_mode) begin
        next_st.trail_buf = wdat;
      end else if (mode == M_IDLE) begin
        next_st.trail_buf = wdat;
        next_st.trail_act = wdat;
      end else begin
        next_st.trail_act = wdat;
        next_st.trail_buf = wdat;
        next_st.arm_trail = 1'b1;
      end
    end

    // Capture and compare actions, stopped while halted
    if (run) begin
      if (pwm_out_mode) begin
        if (new_count && hit_lead) begin
          do_lead = 1'b1;
          ev_flag = 1'b1;
          next_st.in_window = 1'b0;
        end
        if (new_count && hit_trail) begin
          do_trail = 1'b1;
          next_st.in_window = 1'b1;
        end
        // Copy buffer only between trail edge and next lead edge
        if (st.in_window && !(new_count && hit_lead)) begin
          next_st.trail_act = st.trail_buf;
        end
      end else if (cmp_mode) begin
        if (st.arm_lead && new_count && hit_lead) begin
          do_lead = 1'b1;
          next_st.arm_lead = 1'b0;
          ev_flag = ev_flag | mode[0];
        end
        if (st.arm_trail && new_count && hit_trail) begin
          do_trail = 1'b1;
          next_st.arm_trail = 1'b0;
          ev_flag = 1'b1;
        end
      end else if (mode == M_PWCAP) begin
        if (pin_edge_b) begin
          next_st.trail_buf = count;
          next_st.pw_lead_seen = 1'b1;
        end
        if (pin_edge_a) begin
          next_st.lead = count;
          next_st.trail_act = st.trail_buf;
          ev_flag = 1'b1;
        end
      end else if (mode == M_PERCAP || mode == M_EDGECAP) begin
        if (pin_edge_a) begin
          next_st.lead = count;
          next_st.trail_act = st.trail_buf;
          next_st.trail_buf = count;
          next_st.first_done = 1'b1;
          ev_flag = st.first_done || (mode == M_EDGECAP);
        end
      end
    end

    // Output flip-flop: both together give zero
    if ((do_lead && do_trail) || (f_lead && f_trail)) begin
      next_st.outff = 1'b0;
    end else if (do_lead || f_lead) begin
      next_st.outff = 1'b1;
    end else if (do_trail || f_trail) begin
      next_st.outff = 1'b0;
    end
    if (pwm_out_mode && run && hold_high) begin
      next_st.outff = 1'b1;
    end

    // Flag: clear needs prior read as set and no new event; set wins
    if (rd_stat && st.flag) begin
      next_st.flag_seen = 1'b1;
    end
    if (wr_stat && !wdat[B_FLAG] && st.flag_seen) begin
      next_st.flag = 1'b0;
      next_st.flag_seen = 1'b0;
    end
    if (ev_flag) begin
      next_st.flag = 1'b1;
      next_st.flag_seen = 1'b0;
    end
    if (mode == M_IDLE) begin
      next_st.flag = 1'b0;
      next_st.flag_seen = 1'b0;
    end
  end

  // Register the whole state
  always_ff @(posedge core_clk) begin
    if (srst) begin
      st <= '0;
      st.ctrl <= CTRL_RST;
      st.lead <= DATA_RST;
      st.trail_buf <= DATA_RST;
      st.trail_act <= DATA_RST;
    end else begin
      st <= next_st;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs
  logic drive_val;
  assign drive_val = st.outff ^ pol;
  always_comb begin
    pin_out = out_modes ? drive_val : 1'b0;
    // Open drain only pulls low; totem pole drives in every output mode
    if (!out_modes) begin
      pin_oe = 1'b0;
    end else if (st.ctrl[B_DRIVE]) begin
      pin_oe = !drive_val;
    end else begin
      pin_oe = 1'b1;
    end
  end
  assign irq_level = st.flag ? st.ctrl[B_PRIO_HI:B_PRIO_LO] : 3'b000;
  assign irq_arb_id = {st.ctrl[B_ARB], module_arb};
  assign avs_waitrequest = (st.bus == BUS_IDLE);
  assign avs_readdata = st.rdata;
endmodule

// >>> tb/dapc_unit_props.sv
// Checker: port-level properties of the dual action capture/compare unit
module dapc_unit_props (
  input wire logic core_clk,
  input wire logic srst,
  input wire logic [15:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  input wire logic halt_req,
  input wire logic [2:0] module_arb,
  input wire logic pin_out,
  input wire logic pin_oe,
  input wire logic [2:0] irq_level,
  input wire logic [3:0] irq_arb_id
);
  timeunit 1ns;
  timeprecision 1ps;
  import dapc_pkg::*;
  logic took; // Request accepted at this edge
  logic [15:0] shadow; // Control bits as last written
  logic out_mode; // Compare or PWM mode selected
  assign took = (avs_read || avs_write) && avs_waitrequest;
  assign out_mode = shadow[3] || (shadow[3:1] == M_CMP_PFX);
  // Track status writes; refused byte lanes leave the copy alone, as in the unit
  always_ff @(posedge core_clk) begin
    if (srst) begin
      shadow <= 16'h0000;
    end else if (took && avs_write && avs_address == OFS_STATUS && avs_byteenable[1:0] == 2'b11) begin
      shadow <= avs_writedata[15:0] & CTRL_WMASK;
    end
  end
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (srst);
  // Answer: one low cycle of waitrequest, then idle again
  sequence s_answer;
    !avs_waitrequest ##1 avs_waitrequest;
  endsequence
  // Halt held with no register traffic, so nothing may move
  sequence s_halted;
    (halt_req && !took) [*3];
  endsequence
  AST_ANSWER: assert property (took |=> s_answer)
    else $error("answer not one cycle after request");
  AST_RSVD_ZERO: assert property (took && avs_read && avs_address == OFS_RSVD |=> avs_readdata == 32'h0000_0000)
    else $error("reserved word read nonzero");
  AST_UPPER_ZERO: assert property (!avs_waitrequest |-> avs_readdata[31:16] == 16'h0000)
    else $error("upper read half nonzero");
  AST_ARB_ID: assert property ($stable(module_arb) && $stable(shadow) |-> irq_arb_id == {shadow[B_ARB], module_arb})
    else $error("arbitration id wrong");
  AST_PRIO_LEVEL: assert property (irq_level != 3'h0 && $stable(shadow) |-> irq_level == shadow[14:12])
    else $error("request level differs from priority field");
  AST_IDLE_NO_IRQ: assert property (shadow[3:0] == M_IDLE && $stable(shadow) |-> irq_level == 3'h0)
    else $error("request while idle");
  AST_INPUT_NO_DRIVE: assert property (!out_mode && $stable(shadow) |-> !pin_oe && !pin_out)
    else $error("pin driven in input mode");
  AST_TOTEM: assert property (out_mode && !shadow[B_DRIVE] && $stable(shadow) |-> pin_oe)
    else $error("totem pole output not driven");
  AST_OPEN_DRAIN: assert property (out_mode && shadow[B_DRIVE] && $stable(shadow) |-> !(pin_oe && pin_out))
    else $error("open drain drove high");
  AST_HALT_FREEZE: assert property (s_halted |-> $stable(pin_out) && $stable(irq_level))
    else $error("output moved during halt");
endmodule
bind dapc_unit dapc_unit_props i_dapc_unit_props (.core_clk(core_clk), .srst(srst), .avs_address(avs_address),
  .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
  .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .halt_req(halt_req), .module_arb(module_arb),
  .pin_out(pin_out), .pin_oe(pin_oe), .irq_level(irq_level), .irq_arb_id(irq_arb_id));

// >>> tb/dapc_tbase.sv
// Partner: two counters in one process driving the time base buses
module dapc_tbase (
  input wire logic core_clk,
  input wire logic srst,
  output logic [15:0] tbb_a,
  output logic [15:0] tbb_b
);
  timeunit 1ns;
  timeprecision 1ps;
  // Bus A counts up and bus B down, so the chosen bus shows in the duty ratio
  always_ff @(posedge core_clk) begin
    if (srst) begin
      tbb_a <= 16'h0000;
      tbb_b <= 16'h0000;
    end else begin
      tbb_a <= tbb_a + 16'h0001;
      tbb_b <= tbb_b - 16'h0001;
    end
  end
endmodule

// >>> tb/dapc_unit_tb.sv
// Testbench: register-level scenarios for the capture/compare unit
module dapc_unit_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import dapc_pkg::*;
  logic core_clk, srst, halt_req, pin_in, pin_out, pin_oe;
  logic [2:0] module_arb, irq_level;
  logic [3:0] irq_arb_id;
  logic [15:0] tbb_a, tbb_b, rq, dq;
  dapc_req_t req;
  dapc_rsp_t rsp;
  int error_cnt = 0;
  int compares = 0;
  int hi;
  // Flag after rise, fall, rise for modes 1 to 3; bit e is the value after edge e
  // Pulse width and edge capture flag on the first rising (channel A) edge, period capture on the second
  localparam logic [2:0] CAP_EXP [1:3] = '{3'b111, 3'b100, 3'b111};
  dapc_unit i_dapc_unit (.core_clk(core_clk), .srst(srst), .avs_address(req.address), .avs_read(req.read),
    .avs_write(req.write), .avs_writedata(req.writedata), .avs_byteenable(req.byteenable),
    .avs_readdata(rsp.readdata), .avs_waitrequest(rsp.waitrequest), .tbb_a(tbb_a), .tbb_b(tbb_b),
    .halt_req(halt_req), .module_arb(module_arb), .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe),
    .irq_level(irq_level), .irq_arb_id(irq_arb_id));
  dapc_tbase i_dapc_tbase (.core_clk(core_clk), .srst(srst), .tbb_a(tbb_a), .tbb_b(tbb_b));
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  ////////////////////////////////////////////////////////////////////////////
  task automatic summarize();
    $display("compares %0d mismatches %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      error_cnt++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // One bus transfer; request held until waitrequest is sampled low
  task automatic xfer(input logic wr, input logic [15:0] a, input logic [15:0] d, input logic [3:0] be);
    int n;
    n = 0;
    @(posedge core_clk);
    req <= '{address: a, read: !wr, write: wr, writedata: {16'h0000, d}, byteenable: be};
    do begin
      @(posedge core_clk);
      n++;
    end while (rsp.waitrequest !== 1'b0 && n < 50);
    rq = rsp.readdata[15:0];
    req.read <= 1'b0;
    req.write <= 1'b0;
    if (n >= 50) begin
      error_cnt++;
      summarize();
    end
  endtask
  task automatic wr(input logic [15:0] a, input logic [15:0] d);
    xfer(1'b1, a, d, 4'hf);
  endtask
  task automatic rd(input logic [15:0] a);
    xfer(1'b0, a, 16'h0000, 4'hf);
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge core_clk);
  endtask
  // Count high pin cycles over a whole number of periods
  task automatic measure(input int n);
    hi = 0;
    repeat (n) begin
      @(posedge core_clk);
      hi += int'(pin_out === 1'b1);
    end
  endtask
  // Load both edges in idle, where trail writes reach both registers, then start PWM
  task automatic pwm(input logic [15:0] lead, input logic [15:0] trail, input logic [15:0] ctrl, input int exp);
    wr(OFS_STATUS, 16'h0000);
    wr(OFS_LEAD, lead);
    wr(OFS_TRAIL, trail);
    wr(OFS_STATUS, ctrl);
    idle(300);
    measure(512);
    check(hi, exp);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    req = '0;
    halt_req = 1'b0;
    pin_in = 1'b0;
    module_arb = 3'h5;
    srst = 1'b1;
    idle(20);
    srst <= 1'b0;
    rd(OFS_STATUS); check(rq, 16'h0000);
    wr(OFS_RSVD, 16'hffff); rd(OFS_RSVD); check(rq, 16'h0000);
    wr(OFS_STATUS, 16'hfff0); rd(OFS_STATUS); check(rq, 16'h7b10);
    check(irq_arb_id, 4'hd);
    pin_in <= 1'b1;
    idle(6);
    xfer(1'b1, OFS_STATUS, 16'h0000, 4'he); rd(OFS_STATUS); check(rq, 16'h7b90);
    wr(OFS_STATUS, 16'h0000);
    pin_in <= 1'b0;
    // Divide-by-128 PWM, lead 0x10 trail 0x30: 32 of 128 counts high
    pwm(16'h0010, 16'h0030, 16'h000f, 128);
    pwm(16'h0010, 16'h0030, 16'h001f, 384);
    pwm(16'h0010, 16'h0030, 16'h030f, 384);
    pwm(16'h0010, 16'h0010, 16'h000f, 0);
    pwm(16'h0010, 16'h8030, 16'h000f, 512);
    wr(OFS_TRAIL, 16'h0030); idle(300); measure(512); check(hi, 128);
    rd(OFS_TRAIL); check(rq, 16'h0030);
    rd(OFS_STATUS); check(rq[15], 1'b1);
    wr(OFS_STATUS, 16'h500f); idle(300); check(irq_level, 3'h5);
    // Halt: compares freeze, forces and registers still work
    halt_req <= 1'b1;
    idle(3);
    measure(300); check(hi == 0 || hi == 300, 1'b1);
    wr(OFS_STATUS, 16'h504f); rd(OFS_STATUS); check(rq[7], 1'b1);
    wr(OFS_STATUS, 16'h506f); rd(OFS_STATUS); check(rq[7], 1'b0);
    wr(OFS_STATUS, 16'h504f); wr(OFS_STATUS, 16'h502f); rd(OFS_STATUS); check(rq[7], 1'b0);
    rd(OFS_STATUS); wr(OFS_STATUS, 16'h500f); rd(OFS_STATUS); check(rq[15], 1'b0);
    check(irq_level, 3'h0);
    halt_req <= 1'b0;
    // A lead match between the read and the write must win over the clear
    idle(300); rd(OFS_STATUS); idle(300); wr(OFS_STATUS, 16'h500f); rd(OFS_STATUS); check(rq[15], 1'b1);
    wr(OFS_STATUS, 16'h0000); idle(2); rd(OFS_STATUS); check(rq, 16'h0000);
    // Single shot: trail-only flagging ignores the lead match, both-mode does not
    wr(OFS_STATUS, 16'h0004); wr(OFS_LEAD, tbb_a + 16'h0028); idle(80);
    rd(OFS_STATUS); check(rq, 16'h0084);
    wr(OFS_STATUS, 16'h0000); wr(OFS_STATUS, 16'h0005); wr(OFS_LEAD, tbb_a + 16'h0028); idle(80);
    rd(OFS_STATUS); check(rq[15], 1'b1);
    // Capture modes: flag after each of rise, fall, rise
    for (int m = 1; m < 4; m++) begin
      pin_in <= 1'b0;
      wr(OFS_STATUS, 16'h0000);
      idle(8);
      wr(OFS_STATUS, {12'h000, 4'(m)});
      for (int e = 0; e < 3; e++) begin
        pin_in <= ~pin_in;
        idle(8);
        rd(OFS_STATUS); check(rq[15], CAP_EXP[m][e]);
      end
    end
    summarize();
  end
endmodule
